// ==== hdl/supply_temp_monitor_core.sv ====
`timescale 1ns/10ps
module supply_temp_monitor_core #(
  parameter int unsigned TEMP_CONV_CYC = supply_temp_monitor_pkg::TEMP_CONV_CYC,
  parameter int unsigned VOLT_CONV_CYC = supply_temp_monitor_pkg::VOLT_CONV_CYC
) (
  // Core clock, enable and reset
  input  wire logic       REF_CLK,
  input  wire logic       CE,
  input  wire logic       SRST,
  // Register access from the serial target, link clock domain
  input  wire logic       LINK_CLK,
  input  wire logic       LINK_SRST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            REG_ACK,
  output logic            REG_BUSY,
  // Converter
  input  wire logic [7:0] ADC_RESULT,
  output logic      [2:0] ADC_CHAN,
  output logic            ADC_ACTIVE,
  // Open-drain alert pin
  output logic            ALERT_N_OUT,
  output logic            ALERT_N_OE
);

  // Link side: one access at a time, handed over by a toggle pair.
  logic       busy_ff;
  logic       req_tgl_ff;
  logic       lk_wr_ff;
  logic [7:0] lk_addr_ff;
  logic [7:0] lk_wdata_ff;
  logic [7:0] lk_rdata_ff;
  logic       lk_ack_ff;
  logic       ack_s1_ff;
  logic       ack_s2_ff;
  logic       ack_s3_ff;
  logic       ack_edge;

  // Core side.
  logic       req_s1_ff;
  logic       req_s2_ff;
  logic       req_s3_ff;
  logic       ack_tgl_ff;
  logic [7:0] rdata_ff;
  logic       acc_go;
  logic       wr_go;
  logic       rd_go;
  logic       soft_rst;
  logic       clr_all;

  logic [7:0] cfg_ff;
  logic [4:0] mask_ff;
  logic [1:0] tcfg_ff;
  logic [7:0] hot_ff;
  logic [7:0] hyst_ff;
  logic [7:0] vhi_ff [1:4];
  logic [7:0] vlo_ff [1:4];
  logic [7:0] data_ff [0:4];
  logic [4:0] status_ff;
  logic [4:0] nxt_status;
  logic       over_ff;
  logic       nxt_over;
  logic       alert_oe_n_ff;
  logic       alert_out_ff;
  logic       adc_active_ff;

  supply_temp_monitor_pkg::seq_state_type state_ff;
  supply_temp_monitor_pkg::seq_state_type nxt_state;
  logic [2:0]  chan_ff;
  logic [2:0]  nxt_chan;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_win;
  logic        run;
  logic        load;
  logic [7:0]  cur_code;
  logic        t_hot;
  logic        t_cold;
  logic        v_fault;
  logic [4:0]  set_vec;
  logic [4:0] clr_vec;
  logic        comp_mode;
  logic [7:0]  rd_value;

  assign ack_edge  = ack_s2_ff ^ ack_s3_ff;
  assign acc_go    = req_s2_ff ^ req_s3_ff;
  assign wr_go     = acc_go && lk_wr_ff;
  assign rd_go     = acc_go && !lk_wr_ff;
  assign soft_rst  = wr_go && (lk_addr_ff == supply_temp_monitor_pkg::ADDR_MON_CONFIG)
                     && lk_wdata_ff[supply_temp_monitor_pkg::CFG_SOFT_RST];
  // A frozen core keeps the request edge visible, so the soft reset must also wait for the enable.
  assign clr_all   = SRST || (CE && soft_rst);
  assign comp_mode = tcfg_ff[1];
  assign run       = cfg_ff[supply_temp_monitor_pkg::CFG_START]
                     && !cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_CLR];

  assign REG_BUSY    = busy_ff;
  assign REG_RDATA   = lk_rdata_ff;
  assign REG_ACK     = lk_ack_ff;
  assign ADC_CHAN    = chan_ff;
  assign ADC_ACTIVE  = adc_active_ff;
  assign ALERT_N_OE  = alert_oe_n_ff;
  assign ALERT_N_OUT = alert_out_ff;

  // Requests arriving while busy are dropped; the serial target must wait for REG_ACK.
  always_ff @(posedge LINK_CLK) begin
    if (LINK_SRST) begin
      busy_ff     <= 1'b0;
      req_tgl_ff  <= 1'b0;
      lk_wr_ff    <= 1'b0;
      lk_addr_ff  <= 8'h00;
      lk_wdata_ff <= 8'h00;
    end else if (!busy_ff && (REG_WR || REG_RD)) begin
      busy_ff     <= 1'b1;
      req_tgl_ff  <= !req_tgl_ff;
      lk_wr_ff    <= REG_WR;
      lk_addr_ff  <= REG_ADDR;
      lk_wdata_ff <= REG_WDATA;
    end else if (ack_edge) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (LINK_SRST) begin
      ack_s1_ff   <= 1'b0;
      ack_s2_ff   <= 1'b0;
      ack_s3_ff   <= 1'b0;
      lk_ack_ff   <= 1'b0;
      lk_rdata_ff <= 8'h00;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      lk_ack_ff <= ack_edge;
      if (ack_edge) begin
        lk_rdata_ff <= rdata_ff;
      end
    end
  end

  // The serial port keeps working in shutdown, since this path ignores the loop state.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      req_s1_ff  <= 1'b0;
      req_s2_ff  <= 1'b0;
      req_s3_ff  <= 1'b0;
      ack_tgl_ff <= 1'b0;
      rdata_ff   <= 8'h00;
    end else if (CE) begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      if (acc_go) begin
        ack_tgl_ff <= !ack_tgl_ff;
        rdata_ff   <= rd_go ? rd_value : 8'h00;
      end
    end
  end

  always_comb begin
    rd_value = 8'h00;
    case (lk_addr_ff)
      supply_temp_monitor_pkg::ADDR_DATA_TEMP:   rd_value = data_ff[0];
      supply_temp_monitor_pkg::ADDR_DATA_V25:    rd_value = data_ff[1];
      supply_temp_monitor_pkg::ADDR_DATA_V12:    rd_value = data_ff[2];
      supply_temp_monitor_pkg::ADDR_DATA_V33:    rd_value = data_ff[3];
      supply_temp_monitor_pkg::ADDR_DATA_VCC:    rd_value = data_ff[4];
      supply_temp_monitor_pkg::ADDR_TEMP_HOT:    rd_value = hot_ff;
      supply_temp_monitor_pkg::ADDR_TEMP_HYST:   rd_value = hyst_ff;
      supply_temp_monitor_pkg::ADDR_MON_CONFIG:  rd_value = cfg_ff;
      supply_temp_monitor_pkg::ADDR_STATUS:      rd_value = {3'h0, status_ff};
      supply_temp_monitor_pkg::ADDR_MASK:        rd_value = {3'h0, mask_ff};
      supply_temp_monitor_pkg::ADDR_TEMP_CONFIG: rd_value = {6'h00, tcfg_ff};
      default: begin
        for (int i = 1; i <= 4; i++) begin
          if (lk_addr_ff == supply_temp_monitor_pkg::ADDR_LIM_BASE + 8'(2 * (i - 1))) begin
            rd_value = vhi_ff[i];
          end
          if (lk_addr_ff == supply_temp_monitor_pkg::ADDR_LIM_BASE + 8'(2 * i - 1)) begin
            rd_value = vlo_ff[i];
          end
        end
      end
    endcase
  end

  // Control registers; a set soft reset bit is never stored.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      cfg_ff  <= supply_temp_monitor_pkg::RST_MON_CONFIG;
      mask_ff <= supply_temp_monitor_pkg::RST_MASK;
      tcfg_ff <= supply_temp_monitor_pkg::RST_TEMP_CONFIG;
      hot_ff  <= supply_temp_monitor_pkg::RST_TEMP_HOT;
      hyst_ff <= supply_temp_monitor_pkg::RST_TEMP_HYST;
    end else if (CE) begin
      if (soft_rst) begin
        cfg_ff  <= supply_temp_monitor_pkg::RST_MON_CONFIG;
        mask_ff <= supply_temp_monitor_pkg::RST_MASK;
        tcfg_ff <= supply_temp_monitor_pkg::RST_TEMP_CONFIG;
        hot_ff  <= supply_temp_monitor_pkg::RST_TEMP_HOT;
        hyst_ff <= supply_temp_monitor_pkg::RST_TEMP_HYST;
      end else if (wr_go) begin
        case (lk_addr_ff)
          supply_temp_monitor_pkg::ADDR_MON_CONFIG:  cfg_ff  <= lk_wdata_ff & supply_temp_monitor_pkg::CFG_KEEP;
          supply_temp_monitor_pkg::ADDR_MASK:        mask_ff <= lk_wdata_ff[4:0];
          supply_temp_monitor_pkg::ADDR_TEMP_CONFIG: tcfg_ff <= lk_wdata_ff[1:0];
          supply_temp_monitor_pkg::ADDR_TEMP_HOT:    hot_ff  <= lk_wdata_ff;
          supply_temp_monitor_pkg::ADDR_TEMP_HYST:   hyst_ff <= lk_wdata_ff;
          default: begin
          end
        endcase
      end
    end
  end

  // Voltage limit pairs, one per voltage slot.
  for (genvar g = 1; g <= 4; g++) begin : g_lim
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        vhi_ff[g] <= supply_temp_monitor_pkg::RST_VHIGH;
        vlo_ff[g] <= supply_temp_monitor_pkg::RST_VLOW;
      end else if (CE) begin
        if (soft_rst) begin
          vhi_ff[g] <= supply_temp_monitor_pkg::RST_VHIGH;
          vlo_ff[g] <= supply_temp_monitor_pkg::RST_VLOW;
        end else if (wr_go && lk_addr_ff == supply_temp_monitor_pkg::ADDR_LIM_BASE + 8'(2 * (g - 1))) begin
          vhi_ff[g] <= lk_wdata_ff;
        end else if (wr_go && lk_addr_ff == supply_temp_monitor_pkg::ADDR_LIM_BASE + 8'(2 * g - 1)) begin
          vlo_ff[g] <= lk_wdata_ff;
        end
      end
    end
  end

  // Sequencer. Leaving the idle state always loads slot 0, so a restart measures temperature first.
  always_comb begin
    nxt_state = state_ff;
    nxt_chan  = chan_ff;
    load      = 1'b0;
    case (state_ff)
      supply_temp_monitor_pkg::ST_IDLE: begin
        if (run) begin
          nxt_state = supply_temp_monitor_pkg::ST_CONV;
          nxt_chan  = supply_temp_monitor_pkg::CH_TEMP;
          load      = 1'b1;
        end
      end
      supply_temp_monitor_pkg::ST_CONV: begin
        if (cnt_ff == 32'h0000_0000) begin
          nxt_state = supply_temp_monitor_pkg::ST_EVAL;
        end
      end
      supply_temp_monitor_pkg::ST_EVAL: begin
        if (chan_ff != supply_temp_monitor_pkg::CH_LAST) begin
          nxt_state = supply_temp_monitor_pkg::ST_CONV;
          nxt_chan  = chan_ff + 3'h1;
          load      = 1'b1;
        end else if (run) begin
          nxt_state = supply_temp_monitor_pkg::ST_CONV;
          nxt_chan  = supply_temp_monitor_pkg::CH_TEMP;
          load      = 1'b1;
        end else begin
          nxt_state = supply_temp_monitor_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = supply_temp_monitor_pkg::ST_IDLE;
      end
    endcase
  end

  // Window length; 50 Hz mode stretches it by the oscillator ratio instead of slowing a real clock.
  always_comb begin
    logic [47:0] win;
    win = (nxt_chan == supply_temp_monitor_pkg::CH_TEMP) ? 48'(TEMP_CONV_CYC) : 48'(VOLT_CONV_CYC);
    if (cfg_ff[supply_temp_monitor_pkg::CFG_LINE50]) begin
      win = (win * 48'(supply_temp_monitor_pkg::OSC_60_DKHZ)) / 48'(supply_temp_monitor_pkg::OSC_50_DKHZ);
    end
    if (cfg_ff[supply_temp_monitor_pkg::CFG_SLOW]) begin
      win = win * 48'(supply_temp_monitor_pkg::SLOW_FACTOR);
    end
    nxt_win = (win == 48'h0) ? 32'h0000_0000 : win[31:0] - 32'h0000_0001;
  end

  always_ff @(posedge REF_CLK) begin
    if (clr_all) begin
      state_ff      <= supply_temp_monitor_pkg::ST_IDLE;
      chan_ff       <= supply_temp_monitor_pkg::CH_TEMP;
      cnt_ff        <= 32'h0000_0000;
      adc_active_ff <= 1'b0;
    end else if (CE) begin
      state_ff      <= nxt_state;
      chan_ff       <= nxt_chan;
      adc_active_ff <= (nxt_state == supply_temp_monitor_pkg::ST_CONV);
      if (load) begin
        cnt_ff <= nxt_win;
      end else if (cnt_ff != 32'h0000_0000) begin
        cnt_ff <= cnt_ff - 32'h0000_0001;
      end
    end
  end

  // Results are stored as each window closes.
  always_ff @(posedge REF_CLK) begin
    if (clr_all) begin
      for (int i = 0; i < supply_temp_monitor_pkg::NUM_CH; i++) begin
        data_ff[i] <= 8'h00;
      end
    end else if (CE && state_ff == supply_temp_monitor_pkg::ST_CONV && cnt_ff == 32'h0000_0000) begin
      data_ff[chan_ff] <= ADC_RESULT;
    end
  end

  // Fault detection on the slot just stored.
  always_comb begin
    cur_code = data_ff[chan_ff];
    t_hot    = $signed(cur_code) > $signed(hot_ff);
    t_cold   = $signed(cur_code) < $signed(hyst_ff);
    v_fault  = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      if (chan_ff == 3'(i)) begin
        v_fault = (cur_code > vhi_ff[i]) || (cur_code < vlo_ff[i]);
      end
    end
    nxt_over = t_hot ? 1'b1 : (t_cold ? 1'b0 : over_ff);
    set_vec  = 5'h00;
    clr_vec  = 5'h00;
    if (state_ff == supply_temp_monitor_pkg::ST_EVAL) begin
      if (chan_ff == supply_temp_monitor_pkg::CH_TEMP) begin
        if (comp_mode) begin
          set_vec[supply_temp_monitor_pkg::STAT_TEMP] = nxt_over;
          clr_vec[supply_temp_monitor_pkg::STAT_TEMP] = !nxt_over;
        end else if (tcfg_ff == supply_temp_monitor_pkg::TMODE_ONCE) begin
          set_vec[supply_temp_monitor_pkg::STAT_TEMP] = (t_hot && !over_ff) || (t_cold && over_ff);
        end else begin
          set_vec[supply_temp_monitor_pkg::STAT_TEMP] = nxt_over;
        end
      end else begin
        set_vec[chan_ff - 3'h1] = v_fault;
      end
    end
    if (rd_go && lk_addr_ff == supply_temp_monitor_pkg::ADDR_STATUS) begin
      clr_vec = clr_vec | (comp_mode ? 5'h0F : 5'h1F);
    end
    set_vec    = set_vec & ~mask_ff;
    nxt_status = (status_ff & ~clr_vec) | set_vec;
  end

  always_ff @(posedge REF_CLK) begin
    if (clr_all) begin
      status_ff <= 5'h00;
      over_ff   <= 1'b0;
    end else if (CE) begin
      status_ff <= nxt_status;
      if (state_ff == supply_temp_monitor_pkg::ST_EVAL && chan_ff == supply_temp_monitor_pkg::CH_TEMP) begin
        over_ff <= nxt_over;
      end
    end
  end

  // The pin follows unmasked status, so a clearing read releases it two cycles later.
  always_ff @(posedge REF_CLK) begin
    if (clr_all) begin
      alert_oe_n_ff <= 1'b1;
      alert_out_ff  <= 1'b0;
    end else if (CE) begin
      alert_out_ff  <= 1'b0;
      alert_oe_n_ff <= !(cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_EN]
                         && !cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_CLR]
                         && |(status_ff & ~mask_ff));
    end
  end

  chk_start_temp: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && state_ff == supply_temp_monitor_pkg::ST_IDLE && run)
    |=> (state_ff == supply_temp_monitor_pkg::ST_CONV && chan_ff == supply_temp_monitor_pkg::CH_TEMP))
    else $error("Monitoring did not start with temperature.");

  chk_seq_order: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && state_ff == supply_temp_monitor_pkg::ST_EVAL && chan_ff != supply_temp_monitor_pkg::CH_LAST)
    |=> (chan_ff == $past(chan_ff) + 3'h1 && state_ff == supply_temp_monitor_pkg::ST_CONV))
    else $error("Sequence slot did not advance by one.");

  chk_cycle_end: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && state_ff == supply_temp_monitor_pkg::ST_EVAL && chan_ff == supply_temp_monitor_pkg::CH_LAST
     && !run) |=> state_ff == supply_temp_monitor_pkg::ST_IDLE)
    else $error("Loop did not halt after a stopped cycle.");

  chk_volt_fault: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && state_ff == supply_temp_monitor_pkg::ST_EVAL && chan_ff != supply_temp_monitor_pkg::CH_TEMP
     && v_fault && !mask_ff[chan_ff - 3'h1]) |=> status_ff[$past(chan_ff) - 3'h1])
    else $error("Voltage fault did not set its status bit.");

  chk_mask_block: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && mask_ff[0] && !status_ff[0]) |=> !status_ff[0])
    else $error("Masked status bit was set.");

  chk_read_clear: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && rd_go && lk_addr_ff == supply_temp_monitor_pkg::ADDR_STATUS && set_vec == 5'h00)
    |=> status_ff[3:0] == 4'h0)
    else $error("Status read did not clear voltage bits.");

  chk_comp_keep: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && comp_mode && status_ff[4] && clr_vec[4] == 1'b0 && rd_go) |=> status_ff[4])
    else $error("Comparator temperature bit lost on read.");

  chk_alert_gate: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && (!cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_EN] || cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_CLR]))
    |=> ALERT_N_OE)
    else $error("Alert driven while disabled or cleared.");

  chk_alert_drive: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && !soft_rst && cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_EN] && !cfg_ff[supply_temp_monitor_pkg::CFG_IRQ_CLR]
     && |(status_ff & ~mask_ff)) |=> !ALERT_N_OE)
    else $error("Unmasked status did not drive the alert.");

  chk_soft_reset: assert property (@(posedge REF_CLK) disable iff (SRST)
    (CE && soft_rst) |=> (cfg_ff == 8'h00 && status_ff == 5'h00 && state_ff == supply_temp_monitor_pkg::ST_IDLE))
    else $error("Soft reset did not restore defaults.");

endmodule : supply_temp_monitor_core

// ==== inc/supply_temp_monitor_pkg.sv ====
package supply_temp_monitor_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_DATA_V25    = 8'h20;
  localparam logic [7:0] ADDR_DATA_V12    = 8'h21;
  localparam logic [7:0] ADDR_DATA_V33    = 8'h22;
  localparam logic [7:0] ADDR_DATA_VCC    = 8'h23;
  localparam logic [7:0] ADDR_DATA_TEMP   = 8'h27;
  localparam logic [7:0] ADDR_LIM_BASE    = 8'h2B;
  localparam logic [7:0] ADDR_TEMP_HOT    = 8'h39;
  localparam logic [7:0] ADDR_TEMP_HYST   = 8'h3A;
  localparam logic [7:0] ADDR_MON_CONFIG  = 8'h41;
  localparam logic [7:0] ADDR_STATUS      = 8'h42;
  localparam logic [7:0] ADDR_MASK        = 8'h43;
  localparam logic [7:0] ADDR_TEMP_CONFIG = 8'h4B;

  // Reset values.
  localparam logic [7:0] RST_VHIGH       = 8'hD3;
  localparam logic [7:0] RST_VLOW        = 8'hAD;
  localparam logic [7:0] RST_TEMP_HOT    = 8'h50;
  localparam logic [7:0] RST_TEMP_HYST   = 8'h41;
  localparam logic [7:0] RST_MON_CONFIG  = 8'h00;
  localparam logic [4:0] RST_MASK        = 5'h00;
  localparam logic [1:0] RST_TEMP_CONFIG = 2'h0;

  // Configuration fields; bits 2 and 6 are reserved and read as zero.
  localparam int         CFG_START    = 0;
  localparam int         CFG_IRQ_EN   = 1;
  localparam int         CFG_IRQ_CLR  = 3;
  localparam int         CFG_LINE50   = 4;
  localparam int         CFG_SLOW     = 5;
  localparam int         CFG_SOFT_RST = 7;
  localparam logic [7:0] CFG_KEEP     = 8'h3B;

  // Sequence slots; slot 0 is temperature, slots 1..4 map to status bits 0..3.
  localparam int         NUM_CH    = 5;
  localparam logic [2:0] CH_TEMP   = 3'h0;
  localparam logic [2:0] CH_LAST   = 3'h4;
  localparam int         STAT_TEMP = 4;

  // Temperature alert modes.
  localparam logic [1:0] TMODE_DEFAULT = 2'h0;
  localparam logic [1:0] TMODE_ONCE    = 2'h1;

  // Conversion timing.
  localparam int unsigned CLK_KHZ       = 125000;
  localparam int unsigned TEMP_CONV_MS  = 66;
  localparam int unsigned VOLT_CONV_MS  = 33;
  localparam int unsigned TEMP_CONV_CYC = TEMP_CONV_MS * CLK_KHZ;
  localparam int unsigned VOLT_CONV_CYC = VOLT_CONV_MS * CLK_KHZ;
  localparam int unsigned OSC_60_DKHZ   = 614;
  localparam int unsigned OSC_50_DKHZ   = 512;
  localparam int unsigned SLOW_FACTOR   = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_EVAL = 3'b100
  } seq_state_type;

endpackage : supply_temp_monitor_pkg

// ==== testbench/adc_model.sv ====
`timescale 1ns/10ps
module adc_model (
  // Converter handshake
  input  wire logic       REF_CLK,
  input  wire logic [2:0] ADC_CHAN,
  input  wire logic       ADC_ACTIVE,
  // Converter result
  output logic      [7:0] ADC_RESULT
);
  logic [7:0] code [5];
  // Outside a window the code is inverted, so a late sample cannot match by luck.
  always_comb ADC_RESULT = ADC_ACTIVE ? code[ADC_CHAN] : ~code[ADC_CHAN];
endmodule : adc_model

// ==== testbench/supply_temp_monitor_core_tb.sv ====
`timescale 1ns/10ps
module supply_temp_monitor_core_tb;
  logic REF_CLK = 0, LINK_CLK = 0, SRST = 1, LINK_SRST = 1, REG_WR = 0, REG_RD = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, ADC_RESULT;
  logic REG_ACK, REG_BUSY, ADC_ACTIVE, ALERT_N_OUT, ALERT_N_OE, act_q = 0;
  logic [2:0] ADC_CHAN, exp_ch = 0;
  int fails = 0, tests_run = 0, cycles = 0;
  always #4 REF_CLK = ~REF_CLK;
  always #15 LINK_CLK = ~LINK_CLK;
  supply_temp_monitor_core #(.TEMP_CONV_CYC(20), .VOLT_CONV_CYC(10)) dut (.REF_CLK(REF_CLK), .CE(1'b1),
    .SRST(SRST), .LINK_CLK(LINK_CLK), .LINK_SRST(LINK_SRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .REG_BUSY(REG_BUSY), .ADC_RESULT(ADC_RESULT), .ADC_CHAN(ADC_CHAN), .ADC_ACTIVE(ADC_ACTIVE),
    .ALERT_N_OUT(ALERT_N_OUT), .ALERT_N_OE(ALERT_N_OE));
  adc_model adc (.REF_CLK(REF_CLK), .ADC_CHAN(ADC_CHAN), .ADC_ACTIVE(ADC_ACTIVE), .ADC_RESULT(ADC_RESULT));
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string m);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: %s seen %h want %h", $time, m, seen, want);
    end
  endtask : check
  task close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // The request is held until the acknowledge is seen; repeats while busy are dropped by the core.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge LINK_CLK);
    REG_WR = wr;
    REG_RD = !wr;
    REG_ADDR = a;
    REG_WDATA = d;
    n = 0;
    do begin
      @(negedge LINK_CLK);
      n++;
    end while (REG_ACK !== 1'b1 && n < 40);
    q = REG_RDATA;
    REG_WR = 0;
    REG_RD = 0;
    check({7'h0, REG_BUSY}, 8'h00, "busy after ack");
    if (n >= 40) check(8'h00, 8'h01, "no acknowledge");
  endtask : acc
  // Measures the next complete temperature window in core clock cycles.
  task automatic win_len(input logic [7:0] want);
    int n;
    for (int i = 0; i < 400 && ADC_CHAN === 3'h0; i++) @(negedge REF_CLK);
    for (int i = 0; i < 400 && !(ADC_CHAN === 3'h0 && ADC_ACTIVE === 1'b1); i++) @(negedge REF_CLK);
    n = 0;
    while (ADC_ACTIVE === 1'b1 && n < 400) begin
      @(negedge REF_CLK);
      n++;
    end
    check(8'(n), want, "window length");
  endtask : win_len
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    check(q, want, "read data");
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc
  task automatic wait_oe(input logic v, input int lim);
    for (int i = 0; i < lim && ALERT_N_OE !== v; i++) @(negedge REF_CLK);
    check({7'h0, ALERT_N_OE}, {7'h0, v}, "alert enable");
  endtask : wait_oe
  always @(negedge REF_CLK) begin
    if (ADC_ACTIVE === 1'b1 && act_q !== 1'b1) begin
      check({5'h0, ADC_CHAN}, {5'h0, exp_ch}, "slot order");
      exp_ch = (exp_ch == 3'h4) ? 3'h0 : exp_ch + 3'h1;
    end
    act_q = ADC_ACTIVE;
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    adc.code = '{8'h90, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
    cyc(12);
    SRST = 0;
    LINK_SRST = 0;
    repeat (2) @(posedge LINK_CLK);
    rd(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h00);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h00);
    rd(8'h7F, 8'h00);
    wr(8'h2B, 8'hD3);
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h03);
    adc.code[2] = 8'hE0;
    wait_oe(1'b0, 200);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h02);
    cyc(4);
    check({7'h0, ALERT_N_OE}, 8'h01, "released by read");
    check({7'h0, ALERT_N_OUT}, 8'h00, "pin level");
    wait_oe(1'b0, 100);
    wr(supply_temp_monitor_pkg::ADDR_MASK, 8'h02);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h02);
    cyc(150);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h00);
    check({7'h0, ALERT_N_OE}, 8'h01, "masked");
    wr(supply_temp_monitor_pkg::ADDR_TEMP_CONFIG, 8'h02);
    adc.code[0] = 8'h60;
    wait_oe(1'b0, 150);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h10);
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h10);
    check({7'h0, ALERT_N_OE}, 8'h00, "comparator hold");
    adc.code[0] = 8'h10;
    wait_oe(1'b1, 150);
    adc.code[1] = 8'h10;
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h01);
    cyc(150);
    check({7'h0, ALERT_N_OE}, 8'h01, "gated off");
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h03);
    wait_oe(1'b0, 150);
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h0B);
    cyc(8);
    check({7'h0, ALERT_N_OE}, 8'h01, "forced off");
    rd(supply_temp_monitor_pkg::ADDR_STATUS, 8'h01);
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h01);
    for (int i = 0; i < 100 && ADC_CHAN !== 3'h2; i++) @(negedge REF_CLK);
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h00);
    cyc(150);
    check({7'h0, ADC_ACTIVE}, 8'h00, "halted");
    check({5'h0, exp_ch}, 8'h00, "cycle finished");
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h09);
    cyc(40);
    check({7'h0, ADC_ACTIVE}, 8'h00, "start blocked");
    rd(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h09);
    adc.code[0] = 8'h20;
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h01);
    cyc(40);
    rd(supply_temp_monitor_pkg::ADDR_DATA_TEMP, 8'h20);
    win_len(8'h14);
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h21);
    win_len(8'(20 * supply_temp_monitor_pkg::SLOW_FACTOR));
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h11);
    win_len(8'((20 * supply_temp_monitor_pkg::OSC_60_DKHZ) / supply_temp_monitor_pkg::OSC_50_DKHZ));
    wr(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h80);
    rd(supply_temp_monitor_pkg::ADDR_MON_CONFIG, 8'h00);
    rd(supply_temp_monitor_pkg::ADDR_MASK, 8'h00);
    rd(supply_temp_monitor_pkg::ADDR_TEMP_HOT, 8'h50);
    close_out;
  end
endmodule : supply_temp_monitor_core_tb
